/* logic/down_timer_pkg.sv */
// Constants for the prescaled down timer: register map, field positions,
// reset values and the clock-divide ratio. No assumptions on surroundings.
package down_timer_pkg;
  localparam logic [7:0] PRESCALE_ADDR = 8'hd2;
  localparam logic [7:0] COUNT_ADDR = 8'hd3;
  localparam logic [7:0] CTRL_ADDR = 8'hd4;
  localparam int PRESCALE_W = 7;
  localparam int COUNT_W = 8;
  localparam int TAP_W = 3;
  localparam logic [6:0] PRESCALE_RESET = 7'h7f;
  localparam logic [7:0] COUNT_RESET = 8'hff;
  localparam logic [7:0] COUNT_ZERO = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int ZERO_FLAG_BIT = 7;
  localparam int IRQ_EN_BIT = 6;
  localparam int RUN_BIT = 3;
  localparam int TAP_LSB = 0;
  localparam int TAP_MSB = 2;
  localparam int TIMER_VECTOR = 3;
  localparam int INT_DIV = 12;
  localparam logic [3:0] INT_DIV_LAST = 4'hb;
endpackage : down_timer_pkg

/* logic/tick_divider.sv */
// One-cycle enable every INT_DIV clock cycles.
// Assumes a single clock; runs freely from reset.
`timescale 1ns/10ps
`default_nettype none
module tick_divider
  import down_timer_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  output logic tick
);
  logic [3:0] div_reg;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      div_reg <= 4'h0;
    else if (div_reg == INT_DIV_LAST)
      div_reg <= 4'h0;
    else
      div_reg <= div_reg + 4'h1;
  end

  assign tick = (div_reg == INT_DIV_LAST);
endmodule : tick_divider
`default_nettype wire

/* logic/prescaled_down_timer.sv */
// Prescaled 8-bit down timer with data-space register port.
// Assumes a simple synchronous processor data bus: addr, wdata, write and read strobes.
//
// Overview of operation
// - 8-bit down counter fed by a 7-bit prescaler, 2^15 longest span.
// - Counter readable/writable at 0D3h, prescaler readable at 0D2h.
// - Counter decrements once per rising edge of selected prescaler tap.
// - Decrement to zero sets the zero-reached flag.
// - Zero with interrupt enable raises the timer interrupt request, vector 3.
// - Timer interrupt request also serves as WAIT wakeup.
// - Prescaler clocked by internal clock divided by twelve, decrementing.
// - Tap: factor 1 uses prescaler input, factor 2^n uses bit n-1.
// - Run bit clear holds prescaler all ones and stops counting.
// - With run bit set software may load prescaler 0 to 7Fh.
// - Writing 00h to counter or setting flag bit sets flag.
// - Reset: counter FFh, prescaler 7Fh, control cleared.
// - Counter write beats coincident decrement to zero; no flag then unless the write is 00h.
// - Tap select code n divides by 2^n, 1 through 128.
// - Control at 0D4h: flag 7, irq enable 6, run 3, tap 2..0.
`timescale 1ns/10ps
`default_nettype none
module prescaled_down_timer
  import down_timer_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic write_en,
  input wire logic read_en,
  output logic [7:0] rdata,
  output logic timer_irq,
  output logic wake_request
);
  logic [PRESCALE_W-1:0] prescale_count_reg;
  logic [COUNT_W-1:0] down_count_reg;
  logic zero_reached_flag_reg;
  logic zero_irq_enable_reg;
  logic prescale_run_reg;
  logic [TAP_W-1:0] tap_select_reg;
  logic [7:0] rdata_reg;
  logic [PRESCALE_W-1:0] prescale_next;
  logic [PRESCALE_W:0] tap_vec;
  logic [PRESCALE_W-1:0] prescale_prev_reg;
  logic [PRESCALE_W:0] tap_prev_vec;
  logic tap_prev;
  logic [PRESCALE_W-1:0] tap_mask;
  logic tap_now;
  logic count_step;
  logic in_tick;
  logic wr_prescale;
  logic wr_count;
  logic wr_ctrl;
  logic hit_zero;

  tick_divider u_div
  (
    .clk(clk),
    .reset(reset),
    .tick(in_tick)
  );

  assign wr_prescale = write_en && (addr == PRESCALE_ADDR);
  assign wr_count = write_en && (addr == COUNT_ADDR);
  assign wr_ctrl = write_en && (addr == CTRL_ADDR);

  // Prescaler decrements on each divided tick while running
  assign prescale_next = prescale_count_reg - 7'h01;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prescale_count_reg <= PRESCALE_RESET;
    else if (!prescale_run_reg)
      prescale_count_reg <= PRESCALE_RESET;
    else if (wr_prescale)
      prescale_count_reg <= wdata[PRESCALE_W-1:0];
    else if (in_tick)
      prescale_count_reg <= prescale_next;
  end

  // Tap 0 is the prescaler input itself: a one-cycle high pulse per tick
  assign tap_vec = {prescale_count_reg, in_tick};
  assign tap_now = tap_vec[tap_select_reg];
  // Low tapped bits read all ones right after the tapped bit rises by counting down
  assign tap_mask = PRESCALE_W'((8'h01 << tap_select_reg) - 8'h01);

  // The previous value of the whole prescaler is kept, not of the tap output, so that
  // switching the tap, or starting the prescaler later than the cycle right after a stop, never looks like a rising edge
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      prescale_prev_reg <= PRESCALE_RESET;
    else
      prescale_prev_reg <= prescale_count_reg;
  end

  assign tap_prev_vec = {prescale_prev_reg, 1'b0};
  assign tap_prev = tap_prev_vec[tap_select_reg];

  // Rising edge on tap; factor 1 counts every tick directly
  assign count_step = prescale_run_reg &&
                      ((tap_select_reg == 3'h0) ? in_tick : (tap_now && !tap_prev));
  assign hit_zero = count_step && (down_count_reg == 8'h01) && !wr_count;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      down_count_reg <= COUNT_RESET;
    else if (wr_count)
      down_count_reg <= wdata;
    else if (count_step)
      down_count_reg <= down_count_reg - 8'h01;
  end

  // Hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      zero_reached_flag_reg <= 1'b0;
    else if (hit_zero || (wr_count && wdata == COUNT_ZERO))
      zero_reached_flag_reg <= 1'b1;
    else if (wr_ctrl)
      zero_reached_flag_reg <= wdata[ZERO_FLAG_BIT];
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      zero_irq_enable_reg <= 1'b0;
      prescale_run_reg <= 1'b0;
      tap_select_reg <= 3'h0;
    end
    else if (wr_ctrl)
    begin
      zero_irq_enable_reg <= wdata[IRQ_EN_BIT];
      prescale_run_reg <= wdata[RUN_BIT];
      tap_select_reg <= wdata[TAP_MSB:TAP_LSB];
    end
  end

  // Level request until software clears the flag or the irq enable
  assign timer_irq = zero_reached_flag_reg && zero_irq_enable_reg;
  assign wake_request = timer_irq;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      rdata_reg <= 8'h00;
    else if (read_en)
    begin
      unique case (addr)
        PRESCALE_ADDR: rdata_reg <= {1'b0, prescale_count_reg};
        COUNT_ADDR: rdata_reg <= down_count_reg;
        CTRL_ADDR: rdata_reg <= {zero_reached_flag_reg, zero_irq_enable_reg, 2'b00,
                                 prescale_run_reg, tap_select_reg};
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign rdata = rdata_reg;

  // The flag only ever falls through a software write; the hardware never clears it
  AST_STOPPED_HOLDS: assert property (@(posedge clk) disable iff (reset)
    !prescale_run_reg |=> prescale_count_reg == PRESCALE_RESET)
    else $error("prescaler not held while stopped");
  AST_NO_COUNT_STOPPED: assert property (@(posedge clk) disable iff (reset)
    !prescale_run_reg && !wr_count |=> $stable(down_count_reg))
    else $error("counter moved while stopped");
  AST_ZERO_SETS_FLAG: assert property (@(posedge clk) disable iff (reset)
    hit_zero |=> zero_reached_flag_reg && down_count_reg == COUNT_ZERO)
    else $error("zero reached without flag");
  AST_WRAP: assert property (@(posedge clk) disable iff (reset)
    count_step && !wr_count && down_count_reg == COUNT_ZERO |=> down_count_reg == COUNT_RESET)
    else $error("no wrap to FFh");
  AST_WRITE_WINS: assert property (@(posedge clk) disable iff (reset)
    wr_count |=> down_count_reg == $past(wdata))
    else $error("counter write lost");
  AST_IRQ: assert property (@(posedge clk) disable iff (reset)
    hit_zero && zero_irq_enable_reg && !wr_ctrl |=> timer_irq && wake_request)
    else $error("irq missing");
  AST_ZERO_WRITE_FLAG: assert property (@(posedge clk) disable iff (reset)
    wr_count && wdata == COUNT_ZERO |=> zero_reached_flag_reg)
    else $error("zero write did not set flag");
  AST_DIV1_RATE: assert property (@(posedge clk) disable iff (reset)
    prescale_run_reg && tap_select_reg == 3'h0 && count_step |=> !count_step)
    else $error("factor 1 stepped twice in a row");
  AST_PRESCALE_DEC: assert property (@(posedge clk) disable iff (reset)
    prescale_run_reg && in_tick && !wr_prescale && !wr_ctrl |=> prescale_count_reg == $past(prescale_next))
    else $error("prescaler did not decrement");
  AST_CTRL_FLAG_SET: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl && wdata[ZERO_FLAG_BIT] |=> zero_reached_flag_reg)
    else $error("flag bit write did not set flag");
  AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl && !wdata[ZERO_FLAG_BIT] && !hit_zero |=> !zero_reached_flag_reg)
    else $error("software clear of flag lost");
  AST_FLAG_STICKY: assert property (@(posedge clk) disable iff (reset)
    zero_reached_flag_reg && !wr_ctrl |=> zero_reached_flag_reg)
    else $error("flag dropped without software clear");
  AST_PRESCALE_LOAD: assert property (@(posedge clk) disable iff (reset)
    prescale_run_reg && wr_prescale |=> prescale_count_reg == PRESCALE_W'($past(wdata)))
    else $error("prescaler load lost while running");
  AST_TAP_EDGE: assert property (@(posedge clk) disable iff (reset)
    count_step && tap_select_reg != 3'h0 && !$past(wr_prescale) |-> (prescale_count_reg & tap_mask) == tap_mask)
    else $error("counter stepped off the selected tap edge");
  AST_READ_COUNT: assert property (@(posedge clk) disable iff (reset)
    read_en && addr == COUNT_ADDR |=> rdata == $past(down_count_reg))
    else $error("counter read back wrong");
  AST_READ_PRESCALE: assert property (@(posedge clk) disable iff (reset)
    read_en && addr == PRESCALE_ADDR |=> rdata == {1'b0, $past(prescale_count_reg)})
    else $error("prescaler read back wrong");
  AST_READ_CTRL: assert property (@(posedge clk) disable iff (reset)
    read_en && addr == CTRL_ADDR |=> rdata == {$past(zero_reached_flag_reg), $past(zero_irq_enable_reg), 2'b00,
      $past(prescale_run_reg), $past(tap_select_reg)})
    else $error("control read back wrong");

  COV_ZERO: cover property (@(posedge clk) disable iff (reset) hit_zero);
  COV_IRQ: cover property (@(posedge clk) disable iff (reset) $rose(timer_irq));
  COV_WRAP: cover property (@(posedge clk) disable iff (reset)
    count_step && down_count_reg == COUNT_ZERO);
  COV_TAP_STEP: cover property (@(posedge clk) disable iff (reset)
    count_step && tap_select_reg == 3'h7);
  COV_FLAG_BY_WRITE: cover property (@(posedge clk) disable iff (reset)
    wr_ctrl && wdata[ZERO_FLAG_BIT]);
endmodule : prescaled_down_timer
`default_nettype wire

/* tb/test_prescaled_down_timer.sv */
// Self-checking bench for the prescaled down timer.
// Assumes the bench is the only bus master on the data-space strobes.
`timescale 1ns/10ps
`default_nettype none
module test_prescaled_down_timer
  import down_timer_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic write_en = 1'b0;
  logic read_en = 1'b0;
  logic [7:0] rdata;
  logic timer_irq;
  logic wake_request;
  logic [7:0] got;
  int err_count = 0;
  int checks = 0;
  int n;

  always #50 clk = ~clk;

  prescaled_down_timer DUT (
    .clk(clk),
    .reset(reset),
    .addr(addr),
    .wdata(wdata),
    .write_en(write_en),
    .read_en(read_en),
    .rdata(rdata),
    .timer_irq(timer_irq),
    .wake_request(wake_request)
  );

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    write_en <= 1'b1;
    @(posedge clk);
    write_en <= 1'b0;
  endtask : wr

  // Read data is registered, so it is sampled half a cycle after the taking edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    read_en <= 1'b1;
    @(posedge clk);
    read_en <= 1'b0;
    @(negedge clk);
    got = rdata;
    chk(got, e);
  endtask : rd

  // Bounded wait for the request; an exhausted bound ends the run
  task automatic wait_irq(input int limit);
    n = 0;
    while (timer_irq !== 1'b1 && n < limit)
    begin
      @(negedge clk);
      n++;
    end
    if (timer_irq !== 1'b1)
    begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, timer_irq, 1'b1);
      give_verdict();
    end
  endtask : wait_irq

  initial
  begin
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    rd(PRESCALE_ADDR, 8'h7f);
    rd(COUNT_ADDR, 8'hff);
    rd(CTRL_ADDR, 8'h00);
    rd(8'h00, 8'h00);
    $display("Reset test done");
    wr(PRESCALE_ADDR, 8'h10);
    rd(PRESCALE_ADDR, 8'h7f);
    wr(COUNT_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h80);
    chk({7'h0, timer_irq}, 8'h00);
    wr(CTRL_ADDR, 8'h70);
    rd(CTRL_ADDR, 8'h40);
    wr(CTRL_ADDR, 8'hc0);
    @(negedge clk);
    chk({6'h0, timer_irq, wake_request}, 8'h03);
    wr(CTRL_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'h00);
    $display("Flag test done");
    wr(COUNT_ADDR, 8'h03);
    wr(CTRL_ADDR, 8'h48);
    wait_irq(60);
    rd(COUNT_ADDR, 8'h00);
    rd(CTRL_ADDR, 8'hc8);
    repeat (14) @(negedge clk);
    rd(COUNT_ADDR, 8'hff);
    wr(PRESCALE_ADDR, 8'h05);
    rd(PRESCALE_ADDR, 8'h05);
    $display("Count test done");
    // Stopping reloads the prescaler, so each tap needs exactly 2^t ticks of 12 cycles
    for (int t = 0; t < 8; t++)
    begin
      wr(CTRL_ADDR, 8'h00);
      wr(COUNT_ADDR, 8'h01);
      wr(CTRL_ADDR, 8'h48 | 8'(t));
      wait_irq(12 * (1 << t) + 4);
      chk(8'(n >= 12 * ((1 << t) - 1)), 8'h01);
    end
    $display("Tap test done");
    give_verdict();
  end
endmodule : test_prescaled_down_timer
`default_nettype wire
